// ---- core/cmp_ctrl_pkg.sv ----
// Purpose: shared constants and types of the comparator control block
// Assumes: 8-bit register port, analog levels given as unsigned codes
// Notes:   offsets are byte addresses on the plain register port
package cmp_ctrl_pkg;

    // width of an analog level code
    localparam int unsigned VOLT_W = 10;
    typedef logic [VOLT_W-1:0] volt_t;

    // analog levels seen by the comparator front end
    typedef struct packed {
        volt_t       pos_pin;
        volt_t       neg_pin;
        volt_t [3:0] chan;
        volt_t       bandgap;
    } analog_in_t;

    // one register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    // register offsets
    localparam logic [7:0] OFF_CONV_B     = 8'h03;
    localparam logic [7:0] OFF_CMP_CTRL   = 8'h08;
    localparam logic [7:0] OFF_DIN_DIS    = 8'h14;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
    localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h21;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h22;

    // converter control b fields
    localparam int unsigned NEG_MUX_EN_BIT = 6;
    localparam logic [7:0]  CONV_B_WMASK   = 8'he7;
    localparam logic [7:0]  CONV_B_RESET   = 8'h00;

    // comparator control fields
    localparam int unsigned POWER_OFF_BIT = 7;
    localparam int unsigned BANDGAP_BIT   = 6;
    localparam int unsigned OUT_BIT       = 5;
    localparam int unsigned FLAG_BIT      = 4;
    localparam int unsigned IRQ_EN_BIT    = 3;
    localparam int unsigned RSVD_BIT      = 2;
    localparam int unsigned EDGE_MSB      = 1;
    localparam int unsigned EDGE_LSB      = 0;

    // digital input disable fields
    localparam int unsigned POS_OFF_BIT   = 0;
    localparam int unsigned NEG_OFF_BIT   = 1;
    localparam int unsigned DIN_DIS_W     = 6;
    localparam logic [5:0]  DIN_DIS_RESET = 6'h00;

    // interrupt status, clear and enable layout
    localparam int unsigned EVT_BIT = 0;

    // edge selection codes
    typedef enum logic [1:0] {
        EDGE_TOGGLE = 2'b00,
        EDGE_RSVD   = 2'b01,
        EDGE_FALL   = 2'b10,
        EDGE_RISE   = 2'b11
    } edge_mode_t;

endpackage

// ---- core/cmp_edge_detect.sv ----
// Purpose: selectable edge detector on the synchronised output
// Assumes: level comes from a flip-flop
// Notes:   event is a combinational one-cycle pulse
`timescale 1ns/1ps
module cmp_edge_detect
    import cmp_ctrl_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire logic       level,
    input  wire edge_mode_t mode,
    output logic            event_pulse
);
    typedef struct packed {
        logic prev;
    } edge_state_t;

    edge_state_t st_q;
    edge_state_t st_d;

    // previous sample and edge decode
    always_comb begin
        st_d.prev = level; // RULE16
        case (mode)
            EDGE_TOGGLE: event_pulse = level ^ st_q.prev; // RULE10
            EDGE_FALL:   event_pulse = st_q.prev & ~level; // RULE10
            EDGE_RISE:   event_pulse = ~st_q.prev & level; // RULE10
            default:     event_pulse = 1'b0; // RULE16
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    property p_rsvd_silent;
        mode == EDGE_RSVD |-> !event_pulse;
    endproperty
    a_rsvd_silent: assert property (p_rsvd_silent) else $error("reserved mode fired"); // RULE16
    property p_rise_only;
        event_pulse && mode == EDGE_RISE |-> level && !$past(level);
    endproperty
    a_rise_only: assert property (p_rise_only) else $error("rise event without rise"); // RULE10
endmodule

// ---- core/cmp_sync.sv ----
// Purpose: two-stage synchroniser with hold on the second stage
// Assumes: d may change on any cycle
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module cmp_sync (
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic d,
    input  wire logic en,
    output logic      q
);
    typedef struct packed {
        logic s1;
        logic s2;
    } sync_state_t;

    sync_state_t st_q;
    sync_state_t st_d;

    // second stage freezes while en is low
    always_comb begin
        st_d    = st_q;
        st_d.s1 = d;
        if (en) begin
            st_d.s2 = st_q.s1; // RULE5
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.s2;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_enabled3;
        en [*3];
    endsequence
    property p_sync_latency;
        s_enabled3 |-> q == $past(d, 2);
    endproperty
    a_sync_latency: assert property (p_sync_latency) else $error("sync latency wrong"); // RULE5
    property p_sync_hold;
        !en |=> $stable(q);
    endproperty
    a_sync_hold: assert property (p_sync_hold) else $error("output moved while held"); // RULE17
endmodule

// ---- core/comparator_control_logic.sv ----
// Purpose: register and control logic around the on-chip comparator
// Assumes: pins, converter controls and analog codes are synchronous
// Notes:   read data stand only in the cycle after the read strobe
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps

// How it works
// RULE1: result is one when positive exceeds negative
// RULE2: mux on, converter off: channel picks negative
// RULE3: otherwise the negative pin feeds the comparator
// RULE4: bandgap select swaps in the bandgap reference
// RULE5: result is synchronised before the status bit
// RULE6: selected edge sets the event flag
// RULE7: taking the interrupt vector clears the flag
// RULE8: writing one clears flag, zero keeps it
// RULE9: request while flag, enable and global enable
// RULE10: edge codes toggle, reserved, falling, rising
// RULE11: disable bit powers the comparator off
// RULE12: software disables interrupt before mode changes
// RULE13: control bit 2 ignores writes, reads zero
// RULE14: input disable blocks buffer, pin reads zero
// RULE15: converter enable gates the channel path
// RULE16: edges from current versus previous sample
// RULE17: powered off, synchronised output holds still
module comparator_control_logic
    import cmp_ctrl_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       resetn,
    input  wire reg_req_t   req,
    output logic [7:0]      rdata,
    input  wire analog_in_t ain,
    input  wire logic       converter_enable,
    input  wire logic [1:0] channel_select,
    input  wire logic       global_irq_enable,
    input  wire logic       irq_vector_taken,
    input  wire logic       pos_pin_digital,
    input  wire logic       neg_pin_digital,
    output logic            pos_pin_read,
    output logic            neg_pin_read,
    output logic            pos_pin_buffer_off,
    output logic            neg_pin_buffer_off,
    output logic            cmp_power_off,
    output logic            bandgap_select,
    output logic            cmp_out_sync,
    output logic            cmp_irq,
    output logic            irq
);
    typedef struct packed {
        logic [7:0]           conv_b;
        logic                 power_off;
        logic                 bandgap;
        logic                 flag;
        logic                 irq_en;
        edge_mode_t           mode;
        logic [DIN_DIS_W-1:0] din_dis;
        logic                 evt_status;
        logic                 evt_enable;
        logic [7:0]           rdata;
        logic                 cmp_irq;
        logic                 irq;
        logic                 pos_read;
        logic                 neg_read;
    } ctrl_state_t;

    ctrl_state_t st_q;
    ctrl_state_t st_d;

    volt_t pos_level;
    volt_t neg_level;
    logic  neg_mux_enable;
    logic  use_channel;
    logic  raw_result;
    logic  edge_event;
    logic  wr_ctrl;
    logic  flag_clear;
    logic  evt_clear;

    // analog input selection and comparison
    always_comb begin
        neg_mux_enable = st_q.conv_b[NEG_MUX_EN_BIT];
        use_channel    = neg_mux_enable & ~converter_enable; // RULE15
        if (st_q.bandgap) begin
            pos_level = ain.bandgap; // RULE4
        end else begin
            pos_level = ain.pos_pin; // RULE4
        end
        if (use_channel) begin
            neg_level = ain.chan[channel_select]; // RULE2
        end else begin
            neg_level = ain.neg_pin; // RULE3
        end
        raw_result = pos_level > neg_level; // RULE1
    end

    // result crosses into the register side, frozen while powered off
    cmp_sync u_sync (
        .clock  (clock),
        .resetn (resetn),
        .d      (raw_result),
        .en     (~st_q.power_off), // RULE17
        .q      (cmp_out_sync)
    );

    // edge selection on the synchronised output
    cmp_edge_detect u_edge (
        .clock       (clock),
        .resetn      (resetn),
        .level       (cmp_out_sync),
        .mode        (st_q.mode),
        .event_pulse (edge_event)
    );

    // clear sources for the flags
    always_comb begin
        wr_ctrl    = req.wr && (req.addr == OFF_CMP_CTRL);
        flag_clear = (wr_ctrl && req.wdata[FLAG_BIT]) || irq_vector_taken; // RULE7 RULE8
        evt_clear  = req.wr && (req.addr == OFF_IRQ_CLEAR) && req.wdata[EVT_BIT];
    end

    // register writes, flags and read data
    always_comb begin
        st_d       = st_q;
        st_d.rdata = 8'h00;
        if (req.wr) begin
            if (req.addr == OFF_CONV_B) begin
                st_d.conv_b = req.wdata & CONV_B_WMASK;
            end else if (req.addr == OFF_CMP_CTRL) begin
                st_d.power_off = req.wdata[POWER_OFF_BIT]; // RULE11
                st_d.bandgap   = req.wdata[BANDGAP_BIT]; // RULE4
                st_d.irq_en    = req.wdata[IRQ_EN_BIT];
                st_d.mode      = edge_mode_t'(req.wdata[EDGE_MSB:EDGE_LSB]); // RULE13
            end else if (req.addr == OFF_DIN_DIS) begin
                st_d.din_dis = req.wdata[DIN_DIS_W-1:0]; // RULE14
            end else if (req.addr == OFF_IRQ_ENABLE) begin
                st_d.evt_enable = req.wdata[EVT_BIT];
            end
        end
        // set wins over clear
        st_d.flag       = edge_event | (st_q.flag & ~flag_clear); // RULE6 RULE8
        st_d.evt_status = edge_event | (st_q.evt_status & ~evt_clear);
        if (req.rd) begin
            if (req.addr == OFF_CONV_B) begin
                st_d.rdata = st_q.conv_b & CONV_B_WMASK;
            end else if (req.addr == OFF_CMP_CTRL) begin
                st_d.rdata = {st_q.power_off, st_q.bandgap, cmp_out_sync, st_q.flag,
                              st_q.irq_en, 1'b0, st_q.mode}; // RULE5 RULE13
            end else if (req.addr == OFF_DIN_DIS) begin
                st_d.rdata = {2'b00, st_q.din_dis};
            end else if (req.addr == OFF_IRQ_STATUS) begin
                st_d.rdata = {7'h00, st_q.evt_status};
            end else if (req.addr == OFF_IRQ_ENABLE) begin
                st_d.rdata = {7'h00, st_q.evt_enable};
            end
        end
        // interrupt requests
        st_d.cmp_irq = st_d.flag & st_d.irq_en & global_irq_enable; // RULE9
        st_d.irq     = st_d.evt_status & st_d.evt_enable;
        // pin readback through the digital buffers
        st_d.pos_read = pos_pin_digital & ~st_q.din_dis[POS_OFF_BIT]; // RULE14
        st_d.neg_read = neg_pin_digital & ~st_q.din_dis[NEG_OFF_BIT]; // RULE14
    end

    // state register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_q         <= '0;
            st_q.conv_b  <= CONV_B_RESET;
            st_q.din_dis <= DIN_DIS_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from flip-flops
    assign rdata              = st_q.rdata;
    assign pos_pin_read       = st_q.pos_read;
    assign neg_pin_read       = st_q.neg_read;
    assign pos_pin_buffer_off = st_q.din_dis[POS_OFF_BIT];
    assign neg_pin_buffer_off = st_q.din_dis[NEG_OFF_BIT];
    assign cmp_power_off      = st_q.power_off;
    assign bandgap_select     = st_q.bandgap;
    assign cmp_irq            = st_q.cmp_irq;
    assign irq                = st_q.irq;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_read_ctrl;
        req.rd && req.addr == OFF_CMP_CTRL;
    endsequence
    sequence s_wr_flag_one;
        wr_ctrl && req.wdata[FLAG_BIT];
    endsequence

    property p_flag_set;
        edge_event |=> st_q.flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("edge did not set flag"); // RULE6
    property p_flag_clear;
        s_wr_flag_one ##0 !edge_event |=> !st_q.flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared"); // RULE8
    property p_flag_keep;
        st_q.flag && wr_ctrl && !req.wdata[FLAG_BIT] && !irq_vector_taken |=> st_q.flag;
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("zero write cleared flag"); // RULE8
    property p_vector_clear;
        irq_vector_taken && !edge_event |=> !st_q.flag;
    endproperty
    a_vector_clear: assert property (p_vector_clear) else $error("vector left flag"); // RULE7
    property p_irq_cause;
        cmp_irq |-> st_q.flag && st_q.irq_en && $past(global_irq_enable);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("request without cause"); // RULE9
    property p_rsvd_read;
        s_read_ctrl |=> rdata[RSVD_BIT] == 1'b0 && rdata[FLAG_BIT] == $past(st_q.flag);
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("control read wrong"); // RULE13
    property p_pin_blocked;
        pos_pin_buffer_off |=> !pos_pin_read;
    endproperty
    a_pin_blocked: assert property (p_pin_blocked) else $error("disabled pin read one"); // RULE14
    property p_power_write;
        wr_ctrl |=> cmp_power_off == $past(req.wdata[POWER_OFF_BIT]);
    endproperty
    a_power_write: assert property (p_power_write) else $error("power bit not taken"); // RULE11
    property p_neg_pin_path;
        !neg_mux_enable || converter_enable |-> neg_level == ain.neg_pin;
    endproperty
    a_neg_pin_path: assert property (p_neg_pin_path) else $error("negative pin not routed"); // RULE3

    // routing of both comparator inputs, checked from the controls
    property p_conv_gate;
        converter_enable |-> neg_level == ain.neg_pin;
    endproperty
    a_conv_gate: assert property (p_conv_gate) else $error("converter did not gate"); // RULE15
    property p_channel_path;
        neg_mux_enable && !converter_enable |-> neg_level == ain.chan[channel_select];
    endproperty
    a_channel_path: assert property (p_channel_path) else $error("channel not routed"); // RULE2
    property p_bandgap_path;
        st_q.bandgap |-> pos_level == ain.bandgap;
    endproperty
    a_bandgap_path: assert property (p_bandgap_path) else $error("bandgap not routed"); // RULE4
    property p_pos_pin_path;
        !st_q.bandgap |-> pos_level == ain.pos_pin;
    endproperty
    a_pos_pin_path: assert property (p_pos_pin_path) else $error("positive pin not routed"); // RULE4

    // register fields taken on write and shown on read
    sequence s_write_mux;
        req.wr && req.addr == OFF_CONV_B;
    endsequence
    sequence s_write_din;
        req.wr && req.addr == OFF_DIN_DIS;
    endsequence
    property p_mux_write;
        s_write_mux |=> neg_mux_enable == $past(req.wdata[NEG_MUX_EN_BIT]);
    endproperty
    a_mux_write: assert property (p_mux_write) else $error("mux enable not taken"); // RULE2
    property p_bandgap_write;
        wr_ctrl |=> bandgap_select == $past(req.wdata[BANDGAP_BIT]);
    endproperty
    a_bandgap_write: assert property (p_bandgap_write) else $error("bandgap not taken"); // RULE4
    property p_mode_write;
        wr_ctrl |=> st_q.mode == $past(req.wdata[EDGE_MSB:EDGE_LSB]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("edge mode not taken"); // RULE10
    property p_irq_en_write;
        wr_ctrl |=> st_q.irq_en == $past(req.wdata[IRQ_EN_BIT]);
    endproperty
    a_irq_en_write: assert property (p_irq_en_write) else $error("enable not taken"); // RULE9
    property p_din_write;
        s_write_din |=>
            {neg_pin_buffer_off, pos_pin_buffer_off} == $past(req.wdata[NEG_OFF_BIT:POS_OFF_BIT]);
    endproperty
    a_din_write: assert property (p_din_write) else $error("buffer bits not taken"); // RULE14
    property p_out_read;
        s_read_ctrl |=> rdata[OUT_BIT] == $past(cmp_out_sync);
    endproperty
    a_out_read: assert property (p_out_read) else $error("output bit read wrong"); // RULE5
    property p_power_read;
        s_read_ctrl |=> rdata[POWER_OFF_BIT] == $past(st_q.power_off);
    endproperty
    a_power_read: assert property (p_power_read) else $error("power bit read wrong"); // RULE11

    // interrupt requests follow flag, enables and clears
    property p_irq_hold;
        st_q.flag && st_q.irq_en && global_irq_enable && !flag_clear && !wr_ctrl |=> cmp_irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("request missing"); // RULE9
    property p_irq_off;
        !st_q.irq_en && !wr_ctrl |=> !cmp_irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("masked request raised"); // RULE9
    property p_gie_off;
        !global_irq_enable |=> !cmp_irq;
    endproperty
    a_gie_off: assert property (p_gie_off) else $error("request without global"); // RULE9
    property p_irq_level;
        irq |-> st_q.evt_status && st_q.evt_enable;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("status request wrong"); // RULE9
    property p_vector_irq;
        irq_vector_taken && !edge_event |=> !cmp_irq;
    endproperty
    a_vector_irq: assert property (p_vector_irq) else $error("request after vector"); // RULE7
    property p_evt_set;
        edge_event |=> st_q.evt_status;
    endproperty
    a_evt_set: assert property (p_evt_set) else $error("status not set"); // RULE6
    property p_evt_clear;
        evt_clear && !edge_event |=> !st_q.evt_status;
    endproperty
    a_evt_clear: assert property (p_evt_clear) else $error("status not cleared"); // RULE8

    // edge decode seen from the synchronised output
    property p_toggle_seen;
        st_q.mode == EDGE_TOGGLE && $changed(cmp_out_sync) |-> edge_event;
    endproperty
    a_toggle_seen: assert property (p_toggle_seen) else $error("toggle missed"); // RULE10
    property p_rise_seen;
        st_q.mode == EDGE_RISE && $rose(cmp_out_sync) |-> edge_event;
    endproperty
    a_rise_seen: assert property (p_rise_seen) else $error("rise missed"); // RULE6
    property p_fall_seen;
        st_q.mode == EDGE_FALL && $fell(cmp_out_sync) |-> edge_event;
    endproperty
    a_fall_seen: assert property (p_fall_seen) else $error("fall missed"); // RULE10
    property p_fall_only;
        edge_event && st_q.mode == EDGE_FALL |-> !cmp_out_sync && $past(cmp_out_sync);
    endproperty
    a_fall_only: assert property (p_fall_only) else $error("fall event without fall"); // RULE10

    // powered off for two cycles running, no edge can appear
    sequence s_off_twice;
        st_q.power_off [*2];
    endsequence
    property p_off_quiet;
        s_off_twice |-> !edge_event;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("event while off"); // RULE17

    // pin readback through the buffers
    property p_neg_blocked;
        neg_pin_buffer_off |=> !neg_pin_read;
    endproperty
    a_neg_blocked: assert property (p_neg_blocked) else $error("disabled pin read one"); // RULE14
    property p_pos_follows;
        !pos_pin_buffer_off |=> pos_pin_read == $past(pos_pin_digital);
    endproperty
    a_pos_follows: assert property (p_pos_follows) else $error("pin read wrong"); // RULE14
endmodule

// ---- test/analog_front_model.sv ----
// Purpose: behavioural analog front end and comparator input pins
// Assumes: levels are set by the bench right after a rising edge
// Notes:   a pin reads high digitally when its level is at or above half scale
`timescale 1ns/1ps
module analog_front_model
    import cmp_ctrl_pkg::*;
(
    input  wire analog_in_t lvl,
    output analog_in_t      ain,
    output logic            pos_pin_digital,
    output logic            neg_pin_digital
);
    // analog levels reach the comparator unchanged
    assign ain = lvl;
    // digital buffers see the top bit of each pin level
    assign pos_pin_digital = lvl.pos_pin[VOLT_W-1];
    assign neg_pin_digital = lvl.neg_pin[VOLT_W-1];
endmodule

// ---- test/comparator_control_logic_test.sv ----
// Purpose: self-checking bench for the comparator control block
// Assumes: reads answer one cycle after the strobe
// Notes:   random levels from a fixed seed, corner cases by hand
`timescale 1ns/1ps
module comparator_control_logic_test
    import cmp_ctrl_pkg::*;
;
    logic       clock;
    logic       resetn;
    reg_req_t   req;
    logic [7:0] rdata;
    analog_in_t lvl;
    analog_in_t ain;
    logic       converter_enable;
    logic [1:0] channel_select;
    logic       global_irq_enable;
    logic       irq_vector_taken;
    logic       pos_pin_digital;
    logic       neg_pin_digital;
    logic       pos_pin_read;
    logic       neg_pin_read;
    logic       pos_pin_buffer_off;
    logic       neg_pin_buffer_off;
    logic       cmp_power_off;
    logic       bandgap_select;
    logic       cmp_out_sync;
    logic       cmp_irq;
    logic       irq;
    logic       mux_on;
    logic       bg_on;
    logic       want_r;
    logic [95:0] rnd;
    int         mismatches;
    int         cmp_count;
    int         cycles;
    int         seed;

    analog_front_model front (.lvl(lvl), .ain(ain), .pos_pin_digital(pos_pin_digital),
        .neg_pin_digital(neg_pin_digital));

    comparator_control_logic dut (.clock(clock), .resetn(resetn), .req(req), .rdata(rdata),
        .ain(ain), .converter_enable(converter_enable), .channel_select(channel_select),
        .global_irq_enable(global_irq_enable), .irq_vector_taken(irq_vector_taken),
        .pos_pin_digital(pos_pin_digital), .neg_pin_digital(neg_pin_digital),
        .pos_pin_read(pos_pin_read), .neg_pin_read(neg_pin_read),
        .pos_pin_buffer_off(pos_pin_buffer_off), .neg_pin_buffer_off(neg_pin_buffer_off),
        .cmp_power_off(cmp_power_off), .bandgap_select(bandgap_select),
        .cmp_out_sync(cmp_out_sync), .cmp_irq(cmp_irq), .irq(irq));

    // 250 MHz clock
    initial clock = 1'b0;
    always #2 clock = ~clock;

    // hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        cmp_count++;
        if (seen !== want) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req.wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] want);
        @(posedge clock);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req.rd <= 1'b0;
        #1 check(rdata, want);
    endtask

    // drive a clear high or low comparison and let it settle
    task automatic cmp_to(input logic v);
        @(posedge clock);
        lvl.pos_pin <= v ? 10'h258 : 10'h12c;
        lvl.neg_pin <= 10'h1c2;
        tick(4);
    endtask

    // expected comparison from the input routing
    function automatic logic exp_res(analog_in_t l, logic mux, logic conv, logic [1:0] ch,
                                     logic bg);
        volt_t p;
        volt_t n;
        p = bg ? l.bandgap : l.pos_pin;
        n = (mux && !conv) ? l.chan[ch] : l.neg_pin;
        return p > n;
    endfunction

    initial begin
        seed = 85;
        resetn = 1'b0;
        req = '0;
        lvl = '0;
        lvl.neg_pin = 10'h1c2;
        converter_enable = 1'b0;
        channel_select = 2'b00;
        global_irq_enable = 1'b0;
        irq_vector_taken = 1'b0;
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        // reset values, unmapped address
        reg_rd(OFF_CONV_B, 8'h00);
        reg_rd(OFF_CMP_CTRL, 8'h00);
        reg_rd(8'h55, 8'h00);
        reg_wr(OFF_CONV_B, 8'hff);
        reg_rd(OFF_CONV_B, 8'he7);
        reg_wr(OFF_CMP_CTRL, 8'h45);
        reg_rd(OFF_CMP_CTRL, 8'h41);
        check(8'(bandgap_select), 8'h01);
        $display("test registers done");
        // pin buffers with both pins high
        @(posedge clock);
        lvl.pos_pin <= 10'h3ff;
        lvl.neg_pin <= 10'h3ff;
        for (int i = 0; i < 4; i++) begin
            reg_wr(OFF_DIN_DIS, 8'hfc | 8'(i));
            tick(2);
            check(8'({neg_pin_buffer_off, pos_pin_buffer_off}), 8'(i));
            check(8'({neg_pin_read, pos_pin_read}), 8'(~i & 3));
        end
        reg_rd(OFF_DIN_DIS, 8'h3f);
        reg_wr(OFF_DIN_DIS, 8'h00);
        $display("test pins done");
        // random routing, reserved edge code never flags
        for (int i = 0; i < 200; i++) begin
            mux_on = 1'($random(seed));
            bg_on = 1'($random(seed));
            reg_wr(OFF_CONV_B, {1'b0, mux_on, 6'h00});
            reg_wr(OFF_CMP_CTRL, {1'b0, bg_on, 6'h11});
            rnd = {$random(seed), $random(seed), $random(seed)};
            @(posedge clock);
            lvl <= rnd[$bits(analog_in_t)-1:0];
            converter_enable <= rnd[70];
            channel_select <= rnd[72:71];
            tick(3);
            want_r = exp_res(lvl, mux_on, converter_enable, channel_select, bg_on);
            check(8'(cmp_out_sync), 8'(want_r));
            reg_rd(OFF_CMP_CTRL, {1'b0, bg_on, want_r, 5'h01});
        end
        $display("test routing done");
        reg_wr(OFF_CONV_B, 8'h00);
        reg_wr(OFF_CMP_CTRL, 8'h03);
        cmp_to(1'b0);
        @(posedge clock);
        lvl.pos_pin <= 10'h258;
        tick(2);
        check(8'(cmp_out_sync), 8'h01);
        // every edge code against a rise and a fall
        for (int m = 0; m < 4; m++) begin
            for (int v = 0; v < 2; v++) begin
                cmp_to(!v);
                reg_wr(OFF_CMP_CTRL, 8'h10 | 8'(m));
                reg_wr(OFF_IRQ_CLEAR, 8'h01);
                cmp_to(v);
                want_r = (m == 0) || (m == 3 && v == 1) || (m == 2 && v == 0);
                reg_rd(OFF_CMP_CTRL, {2'b00, 1'(v), want_r, 2'b00, 2'(m)});
                reg_rd(OFF_IRQ_STATUS, 8'(want_r));
            end
        end
        $display("test edges done");
        // interrupt request, masks and clears
        reg_wr(OFF_CMP_CTRL, 8'h13);
        cmp_to(1'b0);
        cmp_to(1'b1);
        reg_wr(OFF_CMP_CTRL, 8'h0b);
        tick(2);
        check(8'(cmp_irq), 8'h00);
        @(posedge clock);
        global_irq_enable <= 1'b1;
        tick(2);
        check(8'(cmp_irq), 8'h01);
        reg_wr(OFF_IRQ_ENABLE, 8'h01);
        tick(2);
        check(8'(irq), 8'h01);
        reg_wr(OFF_IRQ_ENABLE, 8'h00);
        tick(2);
        check(8'(irq), 8'h00);
        reg_wr(OFF_IRQ_ENABLE, 8'h01);
        reg_wr(OFF_IRQ_CLEAR, 8'h01);
        tick(2);
        check(8'(irq), 8'h00);
        reg_rd(OFF_IRQ_STATUS, 8'h00);
        reg_rd(OFF_CMP_CTRL, 8'h3b);
        @(posedge clock);
        irq_vector_taken <= 1'b1;
        @(posedge clock);
        irq_vector_taken <= 1'b0;
        tick(2);
        check(8'(cmp_irq), 8'h00);
        reg_rd(OFF_CMP_CTRL, 8'h2b);
        cmp_to(1'b0);
        cmp_to(1'b1);
        reg_wr(OFF_CMP_CTRL, 8'h1b);
        reg_rd(OFF_CMP_CTRL, 8'h2b);
        reg_wr(OFF_CMP_CTRL, 8'h03);
        $display("test interrupts done");
        // power off freezes the output, no events
        reg_wr(OFF_CMP_CTRL, 8'h90);
        cmp_to(1'b0);
        check(8'({cmp_power_off, cmp_out_sync}), 8'h03);
        reg_rd(OFF_CMP_CTRL, 8'ha0);
        $display("test power off done");
        print_verdict();
    end
endmodule
